// ### hdl/itwfo_pkg.sv
// Purpose: shared constants and types for the isolated two-wire frame output block
// Assumes: 200 MHz system clock, host serial clock sampled as a plain input
// Notes: frame layout constants live here only; pin mapping is in itwfo_top
package itwfo_pkg;
    localparam real CLK_PERIOD_NS = 5.0;
    // longest time the serial clock may stay high before a full reset
    localparam real WD_TIME_US = 3.6;
    localparam int WD_CYC = int'($ceil(WD_TIME_US * 1000.0 / CLK_PERIOD_NS));
    localparam int WD_W = 11;

    localparam int SAMPLE_W = 24;
    localparam int FIFO_DEPTH = 32;
    localparam logic [7:0] SYNC_BYTE = 8'hA5;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam int PAY_W = 40;
    localparam logic [5:0] PAY_LEN_SHORT = 6'h20;
    localparam logic [5:0] PAY_LEN_LONG = 6'h28;
    localparam logic [5:0] CRC_LEN = 6'h10;
    localparam logic [1:0] LAST_FRAME = 2'h3;

    // oversampling codes: 0=64 1=128 2=256 3=512
    localparam logic [1:0] OSR_CODE_64 = 2'h0;
    // gain codes: 0=1 1=8 2=16 3=32; bias: 0=half 1=nominal
    localparam logic [1:0] DEF_OSR_CODE = 2'h0;
    localparam logic DEF_BIAS = 1'b1;
    localparam logic [1:0] DEF_GAIN_CODE = 2'h0;

    typedef struct packed {
        logic [1:0] osr_code;
        logic bias_nominal;
        logic [1:0] gain_code;
    } itwfo_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PAY = 2'b01,
        ST_CRC = 2'b10
    } itwfo_state_e;
endpackage

// ### hdl/itwfo_top.sv
// Purpose: interface mode latch and two-wire frame output with clock-high watchdog
// Assumes: all pins synchronous to i_clk; serial clock oversampled by i_clk
// Notes: data bits change after a falling serial clock edge so the host samples on rising
`timescale 1ns/1ps

module itwfo_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input wire logic i_clk, // system clock
    input wire logic i_sys_rst, // sync reset, active high
    input wire logic i_in_valid, // write request
    input wire logic [WIDTH-1:0] i_in_data, // write data
    output logic o_in_ready, // not full, registered
    output logic o_out_valid, // not empty, registered
    output logic [WIDTH-1:0] o_out_data, // head word
    input wire logic i_out_ready // pop request
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic full, empty, next_full, next_empty, do_wr, do_rd;

    always_comb begin
        do_wr = i_in_valid & ~full;
        do_rd = i_out_ready & ~empty;
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        next_full = (next_count == (AW+1)'(DEPTH));
        next_empty = (next_count == '0);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            full <= next_full;
            empty <= next_empty;
        end
    end

    // storage has no reset: contents only matter once counted in
    always_ff @(posedge i_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    assign o_in_ready = ~full;
    assign o_out_valid = ~empty;
    assign o_out_data = mem[rd_ptr];
endmodule

////////////////////////////////////////////////////////////////////////////////

// Summary of operation
// - sample mode pin only when external clock select set
// - mode pin low picks SPI, high picks two-wire
// - mode latched when any reset ends, then held
// - two-wire logic runs from host serial clock edges
// - data output driven in two-wire mode, low when idle
// - repurposed pins captured on mode pin rising edge
// - other settings stay at reset defaults
// - oversampling pins map 64,128,256,512
// - bias pin low half, high nominal
// - gain pins map 1,8,16,32
// - modulator output pin released in two-wire mode
// - ratio 64 frame is sync, 16-bit sample, CRC
// - higher ratios: sync, 24-bit sample, CRC, 56 bits
// - sync word holds A5, settings, frame index
// - four indexed frames per result, then low
// - no frames before first valid result
// - CRC uses polynomial x16+x15+x2+1
// - clock high beyond timeout in two-wire mode forces full reset
// - clock held low never trips the watchdog
module itwfo_top
    import itwfo_pkg::*;
(
    input wire logic i_clk, // system clock, 200 MHz
    input wire logic i_sys_rst, // sync reset, active high
    input wire logic i_external_clock_select, // mode selection enable bit
    input wire logic i_interface_select_pin, // mode pin: 1 = two-wire
    input wire logic i_sck, // host serial clock, sampled
    input wire logic i_reset_pin, // oversampling_select_lo in two-wire mode
    input wire logic i_serial_in_pin, // oversampling_select_hi in two-wire mode
    input wire logic i_chip_select_n_pin, // bias select in two-wire mode
    input wire logic i_oscillator_input_pin, // gain_select_lo in two-wire mode
    input wire logic i_data_ready_pin, // gain_select_hi in two-wire mode
    input wire logic i_sample_valid, // converter result strobe
    input wire logic [itwfo_pkg::SAMPLE_W-1:0] i_channel_sample, // converter result
    output logic o_sample_ready, // fifo can take a result
    output logic o_two_wire_mode, // latched mode
    output itwfo_pkg::itwfo_cfg_s o_cfg, // applied settings
    output logic o_full_reset, // one-cycle watchdog reset to converter
    output logic o_sdo, // serial data output
    output logic o_sdo_oe_n, // low while driving serial data
    output logic o_modulator_output_pin_oe_n // low while modulator pin driven
);
    import itwfo_pkg::*;

    logic sck_q, sel_q, cap_pend, two_wire, rst_int, wd_fire;
    logic next_sck_q, next_sel_q, next_cap_pend, next_two_wire, next_wd_fire;
    logic [WD_W-1:0] wd_cnt, next_wd_cnt;
    itwfo_cfg_s cfg, next_cfg, pins;
    itwfo_state_e state, next_state;
    logic [PAY_W-1:0] sh, next_sh;
    logic [15:0] crc, next_crc;
    logic [5:0] bit_cnt, next_bit_cnt;
    logic [1:0] idx, next_idx;
    logic sdo, next_sdo, fifo_pop, fall, fb;
    logic fifo_valid, fifo_ready;
    logic [SAMPLE_W-1:0] fifo_data;
    logic [5:0] pay_len;

    assign rst_int = i_sys_rst | wd_fire;

    // loose pins keep the fifo ready flag registered at the port
    itwfo_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(rst_int),
        .i_in_valid(i_sample_valid),
        .i_in_data(i_channel_sample),
        .o_in_ready(fifo_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [PAY_W-1:0] build_frame(input itwfo_cfg_s c,
                                                     input logic [1:0] n,
                                                     input logic [SAMPLE_W-1:0] s);
        logic [15:0] sync;
        sync = {SYNC_BYTE, n, c.gain_code, c.bias_nominal, c.osr_code, 1'b0};
        if (c.osr_code == OSR_CODE_64) begin
            build_frame = {sync, s[SAMPLE_W-1 -: 16], 8'h00};
        end else begin
            build_frame = {sync, s};
        end
    endfunction

    always_comb begin
        pins = '{osr_code: {i_serial_in_pin, i_reset_pin},
                 bias_nominal: i_chip_select_n_pin,
                 gain_code: {i_data_ready_pin, i_oscillator_input_pin}};
        next_sck_q = i_sck;
        next_sel_q = i_interface_select_pin;
        fall = sck_q & ~i_sck;
        // counts only while high, so a parked-low clock never trips it
        next_wd_cnt = wd_cnt;
        next_wd_fire = 1'b0;
        if (!i_sck || !two_wire) begin
            next_wd_cnt = '0;
        end else if (wd_cnt != '1) begin
            next_wd_cnt = wd_cnt + 1'b1;
            next_wd_fire = (wd_cnt == WD_W'(WD_CYC));
        end
        next_cap_pend = cap_pend;
        next_two_wire = two_wire;
        next_cfg = cfg;
        if (rst_int) begin
            next_cap_pend = 1'b1;
            next_cfg = '{osr_code: DEF_OSR_CODE, bias_nominal: DEF_BIAS,
                         gain_code: DEF_GAIN_CODE};
        end else begin
            next_cap_pend = 1'b0;
            if (cap_pend && i_external_clock_select) begin
                next_two_wire = i_interface_select_pin;
                if (i_interface_select_pin) begin
                    next_cfg = pins;
                end
            end else if (two_wire && i_interface_select_pin && !sel_q) begin
                next_cfg = pins;
            end
        end
        pay_len = (cfg.osr_code == OSR_CODE_64) ? PAY_LEN_SHORT : PAY_LEN_LONG;
        fb = sh[PAY_W-1] ^ crc[15];
        next_state = state;
        next_sh = sh;
        next_crc = crc;
        next_bit_cnt = bit_cnt;
        next_idx = idx;
        next_sdo = sdo;
        fifo_pop = 1'b0;
        if (rst_int || !two_wire) begin
            next_state = ST_IDLE;
            next_sdo = 1'b0;
            next_idx = '0;
        end else if (fall) begin
            unique case (state)
                ST_IDLE: begin
                    next_sdo = 1'b0;
                    if (fifo_valid) begin
                        next_sh = build_frame(cfg, 2'h0, fifo_data);
                        next_idx = 2'h0;
                        next_crc = CRC_INIT;
                        next_bit_cnt = '0;
                        next_state = ST_PAY;
                    end
                end
                ST_PAY: begin
                    next_sdo = sh[PAY_W-1];
                    next_sh = {sh[PAY_W-2:0], 1'b0};
                    next_crc = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
                    next_bit_cnt = bit_cnt + 1'b1;
                    if (bit_cnt == pay_len - 1'b1) begin
                        next_bit_cnt = '0;
                        next_state = ST_CRC;
                    end
                end
                ST_CRC: begin
                    next_sdo = crc[15];
                    next_crc = {crc[14:0], 1'b0};
                    next_bit_cnt = bit_cnt + 1'b1;
                    if (bit_cnt == CRC_LEN - 1'b1) begin
                        next_bit_cnt = '0;
                        if (idx == LAST_FRAME) begin
                            fifo_pop = 1'b1;
                            next_state = ST_IDLE;
                        end else begin
                            // next frame starts straight after, no idle bit between
                            next_idx = idx + 1'b1;
                            next_sh = build_frame(cfg, idx + 1'b1, fifo_data);
                            next_crc = CRC_INIT;
                            next_state = ST_PAY;
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sck_q <= 1'b0;
            sel_q <= 1'b0;
            wd_cnt <= '0;
            wd_fire <= 1'b0;
            two_wire <= 1'b0;
        end else begin
            sck_q <= next_sck_q;
            sel_q <= next_sel_q;
            wd_cnt <= next_wd_cnt;
            wd_fire <= next_wd_fire;
            two_wire <= next_two_wire;
        end
    end

    always_ff @(posedge i_clk) begin
        cap_pend <= next_cap_pend;
        cfg <= next_cfg;
        if (rst_int) begin
            state <= ST_IDLE;
            sh <= '0;
            crc <= CRC_INIT;
            bit_cnt <= '0;
            idx <= '0;
            sdo <= 1'b0;
        end else begin
            state <= next_state;
            sh <= next_sh;
            crc <= next_crc;
            bit_cnt <= next_bit_cnt;
            idx <= next_idx;
            sdo <= next_sdo;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_sample_ready <= 1'b0;
            o_two_wire_mode <= 1'b0;
            o_cfg <= '{osr_code: DEF_OSR_CODE, bias_nominal: DEF_BIAS,
                       gain_code: DEF_GAIN_CODE};
            o_full_reset <= 1'b0;
            o_sdo <= 1'b0;
            o_sdo_oe_n <= 1'b1;
            o_modulator_output_pin_oe_n <= 1'b1;
        end else begin
            o_sample_ready <= fifo_ready;
            o_two_wire_mode <= two_wire;
            o_cfg <= cfg;
            o_full_reset <= wd_fire;
            o_sdo <= sdo;
            o_sdo_oe_n <= ~two_wire;
            o_modulator_output_pin_oe_n <= two_wire;
        end
    end
endmodule

// ### verification/itwfo_host.sv
// Purpose: host model, makes the serial clock and collects frames
// Assumes: serial clock is i_clk/20, the fastest the device accepts
// Notes: a frame starts at the first 1 seen after idle low
`timescale 1ns/1ps
module itwfo_host (
    input wire logic i_clk, // bench clock
    input wire logic i_run, // toggle serial clock
    input wire logic i_hold, // park serial clock high
    input wire logic i_long, // 56-bit frames
    input wire logic i_sdo, // device data
    output logic o_sck, // serial clock
    output logic o_got, // frame complete
    output logic [55:0] o_frame // frame, right aligned
);
    int ph = 0;
    int n = 0;
    logic [55:0] sh = 56'h0;
    initial begin
        o_sck = 1'b0;
        o_got = 1'b0;
        o_frame = 56'h0;
    end
    always @(posedge i_clk) begin
        o_got <= 1'b0;
        ph = (ph == 9) ? 0 : ph + 1;
        if (i_hold) begin
            o_sck <= 1'b1;
        end else if (!i_run) begin
            o_sck <= 1'b0;
        end else if (ph == 0) begin
            o_sck <= !o_sck;
            // bits are taken on the rising edge, well after the device moved them
            if (!o_sck && (n != 0 || i_sdo)) begin
                sh = (n == 0) ? {55'h0, i_sdo} : {sh[54:0], i_sdo};
                n = n + 1;
                if (n == (i_long ? 56 : 48)) begin
                    o_got <= 1'b1;
                    o_frame <= sh;
                    n = 0;
                end
            end
        end
    end
endmodule

// ### verification/itwfo_top_chk.sv
// Purpose: concurrent checks on itwfo_top ports
// Assumes: every watched output is registered, latencies counted in i_clk cycles
// Notes: the high-clock counter is ours, so alignment slack is a few cycles
`timescale 1ns/1ps
module itwfo_top_chk
    import itwfo_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_sys_rst, // reset
    input wire logic i_sck, // serial clock
    input wire logic o_two_wire_mode, // mode
    input wire logic o_full_reset, // watchdog pulse
    input wire logic o_sdo, // data
    input wire logic o_sdo_oe_n, // data enable
    input wire logic o_modulator_output_pin_oe_n // modulator enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [10:0] hi_cnt, next_hi_cnt;
    logic [3:0] since, next_since;
    always_comb begin
        next_hi_cnt = 11'h000;
        if (i_sck && o_two_wire_mode) next_hi_cnt = hi_cnt + {10'h000, hi_cnt != 11'h7FF};
        next_since = (i_sys_rst || o_full_reset) ? 4'h0 : since + {3'h0, since != 4'hF};
    end
    always_ff @(posedge i_clk) begin
        hi_cnt <= i_sys_rst ? 11'h000 : next_hi_cnt;
        since <= next_since;
    end
    sequence s_sck_fall;
        i_sck ##1 !i_sck;
    endsequence
    // a watchdog reset may clear a bit left standing while the clock is parked high
    a_sdo_fall: assert property ($changed(o_sdo) && !$past(o_full_reset) |->
        $past(i_sck, 3) && !$past(i_sck, 2)) else $error("sdo moved off a clock fall");
    a_oe_drive: assert property (o_two_wire_mode && $past(o_two_wire_mode) |->
        !o_sdo_oe_n) else $error("sdo not driven");
    a_mod_off: assert property (o_two_wire_mode && $past(o_two_wire_mode) |->
        o_modulator_output_pin_oe_n) else $error("modulator pin driven");
    a_pulse_one: assert property (o_full_reset |=> !o_full_reset)
        else $error("reset pulse too long");
    a_low_no_wd: assert property (s_sck_fall ##1 !i_sck [*4] |-> !o_full_reset)
        else $error("watchdog with clock low");
    a_wd_fires: assert property (hi_cnt == WD_CYC |-> ##[0:3] o_full_reset)
        else $error("watchdog missed");
    a_wd_late: assert property (o_full_reset |-> hi_cnt >= WD_CYC - 4)
        else $error("watchdog early");
    a_mode_held: assert property ($changed(o_two_wire_mode) |-> since <= 4'h6)
        else $error("mode moved outside reset");
endmodule
bind itwfo_top itwfo_top_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sck(i_sck),
    .o_two_wire_mode(o_two_wire_mode), .o_full_reset(o_full_reset), .o_sdo(o_sdo),
    .o_sdo_oe_n(o_sdo_oe_n), .o_modulator_output_pin_oe_n(o_modulator_output_pin_oe_n));

// ### verification/tb_isolated_two_wire_frame_output.sv
// Purpose: self-checking bench for itwfo_top
// Assumes: host model paces frames; expectations queued by the driver
// Notes: the full fifo is emptied by the watchdog, not by streaming
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module tb_isolated_two_wire_frame_output;
    import itwfo_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ext = 1'b1, sel = 1'b1, sv = 1'b0, run = 1'b0, hold = 1'b0;
    logic sck, got, rdy, mode, fr, sdo, oe_n, mod_oe_n;
    logic [SAMPLE_W-1:0] samp = 24'h000000;
    logic [55:0] frame, e;
    itwfo_cfg_s p = 5'h00, cfg;
    int seed = 32'h3fa65418;
    int bad_count = 0, check_count = 0, wd_count = 0, i, k;
    logic [55:0] expq[$];
    always #2.5 clk = ~clk;
    itwfo_top i_dut (.i_clk(clk), .i_sys_rst(rst), .i_external_clock_select(ext),
        .i_interface_select_pin(sel), .i_sck(sck), .i_reset_pin(p.osr_code[0]),
        .i_serial_in_pin(p.osr_code[1]), .i_chip_select_n_pin(p.bias_nominal),
        .i_oscillator_input_pin(p.gain_code[0]), .i_data_ready_pin(p.gain_code[1]),
        .i_sample_valid(sv), .i_channel_sample(samp), .o_sample_ready(rdy),
        .o_two_wire_mode(mode), .o_cfg(cfg), .o_full_reset(fr), .o_sdo(sdo),
        .o_sdo_oe_n(oe_n), .o_modulator_output_pin_oe_n(mod_oe_n));
    itwfo_host i_host (.i_clk(clk), .i_run(run), .i_hold(hold), .i_long(p.osr_code != 2'h0),
        .i_sdo(sdo), .o_sck(sck), .o_got(got), .o_frame(frame));
    function automatic logic [15:0] crc(logic [39:0] d, int n);
        logic [15:0] c;
        c = CRC_INIT;
        for (int j = n - 1; j >= 0; j--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[j]) ? CRC_POLY : 16'h0);
        return c;
    endfunction
    function automatic logic [55:0] frm(logic [1:0] n, logic [23:0] s);
        logic [15:0] sy;
        sy = {SYNC_BYTE, n, p.gain_code, p.bias_nominal, p.osr_code, 1'b0};
        if (p.osr_code == OSR_CODE_64) return {8'h00, sy, s[23:8], crc({8'h00, sy, s[23:8]}, 32)};
        return {sy, s, crc({sy, s}, 40)};
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_sim;
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic put(logic [23:0] s);
        for (int j = 0; j < 4; j++) expq.push_back(frm(2'(j), s));
        for (i = 0; i < 100 && rdy !== 1'b1; i++) tick(1);
        if (rdy !== 1'b1) begin
            bad_count++;
            end_sim();
        end
        samp = s;
        sv = 1'b1;
        tick(1);
        sv = 1'b0;
        // let an edge pass so a second call does not raise the strobe in this step
        tick(1);
    endtask
    task automatic drain;
        for (i = 0; i < 40000 && expq.size() != 0; i++) tick(1);
        if (expq.size() != 0) begin
            bad_count++;
            end_sim();
        end
        tick(300);
        `CHK("sdo_idle", 1'b0, sdo)
    endtask
    always @(posedge clk) begin
        if (fr === 1'b1) wd_count++;
        if (got === 1'b1 && expq.size() == 0) begin
            bad_count++;
            $display("[ERR] frame exp none got %0h", frame);
        end else if (got === 1'b1) begin
            e = expq.pop_front();
            `CHK("frame", e, frame)
        end
    end
    initial begin
        p = 5'($random(seed));
        tick(4);
        rst = 1'b0;
        tick(4);
        `CHK("mode", 1'b1, mode)
        `CHK("cfg", p, cfg)
        `CHK("oe_n", 1'b0, oe_n)
        `CHK("mod_oe_n", 1'b1, mod_oe_n)
        run = 1'b1;
        // no sample written yet, so any frame here is reported by the monitor
        tick(400);
        for (k = 0; k < 4; k++) begin
            p = {2'(k), 3'($random(seed))};
            sel = 1'b0;
            tick(3);
            `CHK("mode_hold", 1'b1, mode)
            sel = 1'b1;
            tick(4);
            `CHK("cfg", p, cfg)
            put(24'($random(seed)));
            if (k == 3) put(24'($random(seed)));
            drain();
        end
        run = 1'b0;
        tick(40);
        k = 0;
        for (i = 0; i < 40; i++) begin
            samp = 24'($random(seed));
            sv = rdy;
            k = k + int'(rdy === 1'b1);
            tick(1);
            sv = 1'b0;
            tick(2);
        end
        `CHK("fifo_fill", FIFO_DEPTH, k)
        tick(2000);
        `CHK("wd_low", 0, wd_count)
        sel = 1'b0;
        tick(2);
        hold = 1'b1;
        for (i = 0; i < 1000 && fr !== 1'b1; i++) tick(1);
        `CHK("wd_time", 1'b1, i >= WD_CYC && i < WD_CYC + 10)
        if (fr !== 1'b1) end_sim();
        hold = 1'b0;
        tick(8);
        `CHK("mode_exit", 1'b0, mode)
        `CHK("mod_oe_n", 1'b0, mod_oe_n)
        `CHK("oe_n_spi", 1'b1, oe_n)
        `CHK("cfg_def", {DEF_OSR_CODE, DEF_BIAS, DEF_GAIN_CODE}, cfg)
        run = 1'b1;
        sv = 1'b1;
        tick(1);
        sv = 1'b0;
        tick(3000);
        rst = 1'b1;
        ext = 1'b0;
        sel = 1'b1;
        tick(4);
        rst = 1'b0;
        tick(6);
        `CHK("mode_ext_off", 1'b0, mode)
        end_sim();
    end
endmodule
